// file: trl_pkg.sv
package trl_pkg;
  // data path widths
  localparam int BYTE_W = 8;
  localparam int CELL_W = 10;
  localparam int CELL_PRE = 8;
  localparam int CELL_EOF = 9;
  localparam int BUF_DEPTH = 2;
  // counter and config widths
  localparam int LEN_W = 16;
  localparam int HDR_W = 8;
  localparam int RATIO_W = 19;
  localparam int SCALE_W = 4;
  localparam int GAP_W = 24;
  localparam int NUM_W = 36;
  localparam int DIV_W = 6;
  // standard gap in byte times
  localparam logic [7:0] STD_GAP = 8'h0C;
  // frame spacing counter must exceed this to stretch
  localparam logic [LEN_W-1:0] FRAME_RATE_FLOOR = 16'h000C;
  // payload ratio numerator 256 = 2^8
  localparam int PAYLOAD_SHIFT = 8;
  // divider: one load cycle then one step per numerator bit
  localparam logic [DIV_W-1:0] DIV_LOAD = 6'h25;
  // pipeline cycles between gap exit and next byte on the wire
  localparam logic [GAP_W-1:0] GAP_LEAD = 24'h000002;
  // transmit sequencer states
  typedef enum logic [3:0] {
    TRL_IDLE = 4'b0001,
    TRL_DATA = 4'b0010,
    TRL_CALC = 4'b0100,
    TRL_GAP = 4'b1000
  } trl_state_e;
endpackage

// file: trl_cell_buffer.sv
module trl_cell_buffer #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // flush
  input wire logic flush,
  // fill side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // drain side
  input wire logic rd_ready,
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic do_wr;
  logic do_rd;

  // honest full and empty from the occupancy count
  assign wr_ready = (count_reg != CW'(DEPTH)) && !flush;
  assign rd_valid = (count_reg != '0) && !flush;
  assign rd_data = mem_reg[rd_ptr_reg];
  assign do_wr = wr_valid && wr_ready;
  assign do_rd = rd_valid && rd_ready;

  ////////////////////////////////////////////////////////////////
  // storage, no reset needed on data
  always_ff @(posedge clk)
  begin
    if (do_wr)
    begin
      mem_reg[wr_ptr_reg] <= wr_data;
    end
  end

  // pointers and count; flush drops every held word
  always_ff @(posedge clk)
  begin
    if (rst || flush)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // flush leaves the buffer empty
  a_flush_empties: assert property (@(posedge clk) disable iff (rst) // RL22
    flush |=> !rd_valid && count_reg == '0)
    else $error("buffer not empty after flush");
endmodule

// file: trl_ipg_stretcher.sv
// Overview of operation
// RL1: three gap methods enabled independently per port
// RL2: several methods: largest extra gap wins
// RL3: accumulate bit sums overhead and payload gaps; code ignores the bit and takes the largest while spacing method is on
// RL4: preamble excluded from payload unless selected
// RL5: header subtract drops header bytes from payload
// RL6: header byte count is one global setting
// RL7: length adjustments only affect payload, spacing
// RL8: overhead and payload gaps scaled by 2^S
// RL9: overhead mode imposes compensation value minimum gap
// RL10: payload gap is 2^S*256/R times length
// RL11: total gap is 12 plus extra gap
// RL12: software keeps stretch ratio 1152..518143
// RL13: software keeps scale exponent at most 10
// RL14: fractional gap remainder carried to next frame
// RL15: spacing counter loaded at start of payload
// RL16: spacing counter decremented per payload byte
// RL17: remaining counter stretches gap only above 12
// RL18: sticky flag on cell buffer overflow
// RL19: sticky flag on cell buffer underrun
// RL20: sticky flag whenever a method stretches gap
// RL21: sticky flags cleared by writing one
// RL22: per-port cell buffer, flushable by software
module trl_ipg_stretcher (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // cells from the rewriter
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [trl_pkg::BYTE_W-1:0] in_data,
  input wire logic in_preamble,
  input wire logic in_eof,
  // bytes towards the port module
  output logic out_valid,
  input wire logic out_ready,
  output logic [trl_pkg::BYTE_W-1:0] out_data,
  output logic out_preamble,
  output logic out_eof,
  // per-port method selection
  input wire logic overhead_method_enable,
  input wire logic payload_method_enable,
  input wire logic frame_spacing_method_enable,
  input wire logic gap_accumulate_enable,
  input wire logic preamble_as_payload_sel,
  input wire logic header_subtract_enable,
  // per-port method values
  input wire logic [trl_pkg::SCALE_W-1:0] gap_scale_exponent,
  input wire logic [7:0] gap_compensation_value,
  input wire logic [trl_pkg::RATIO_W-1:0] gap_stretch_ratio,
  input wire logic [trl_pkg::LEN_W-1:0] frame_rate_start,
  // shared by all ports
  input wire logic [trl_pkg::HDR_W-1:0] header_byte_count,
  // buffer maintenance
  input wire logic cell_buffer_flush,
  // sticky status, write one to clear
  output logic cell_buffer_overflow_flag,
  input wire logic cell_buffer_overflow_clear,
  output logic cell_buffer_underrun_flag,
  input wire logic cell_buffer_underrun_clear,
  output logic rate_limit_flag,
  input wire logic rate_limit_clear
);
  import trl_pkg::*;

  ////////////////////////////////////////////////////////////////
  // declarations
  trl_state_e st_reg; // sequencer state
  logic buf_valid; // buffered byte waiting
  logic [CELL_W-1:0] buf_cell; // head of buffer
  logic buf_pre; // head is preamble
  logic buf_eof; // head ends frame
  logic out_free; // output register can take a byte
  logic pop; // byte moves buffer to output
  logic first; // byte opens a frame
  logic is_hdr; // byte counts as header
  logic pay_byte; // byte counts as payload
  logic stall_reg; // offered byte was refused last cycle
  logic ovf_event; // refused byte was withdrawn
  logic unf_event; // buffer ran dry mid-frame
  logic [HDR_W-1:0] hdr_cnt_reg; // non-preamble bytes seen
  logic [HDR_W-1:0] hdr_base;
  logic [LEN_W-1:0] len_reg; // payload length of frame
  logic [LEN_W-1:0] len_base;
  logic seen_reg; // payload has started
  logic seen_base;
  logic [LEN_W-1:0] fr_cnt_reg; // frame spacing counter
  logic [DIV_W-1:0] div_cnt_reg; // divider step counter
  logic [NUM_W-1:0] num_reg; // numerator being shifted out
  logic [NUM_W-1:0] quo_reg; // quotient bits
  logic [RATIO_W:0] rem_reg; // partial remainder
  logic [RATIO_W:0] rem_shift;
  logic [RATIO_W-1:0] frac_reg; // carried fraction numerator
  logic div_done; // extra gap ready this cycle
  logic [GAP_W-1:0] ov_extra;
  logic [GAP_W-1:0] pl_extra;
  logic [GAP_W-1:0] fs_extra;
  logic [GAP_W:0] sum_wide;
  logic [GAP_W-1:0] sum_extra;
  logic [GAP_W-1:0] max_extra;
  logic [GAP_W-1:0] extra_sel; // chosen extra gap
  logic [GAP_W:0] total_wide;
  logic [GAP_W-1:0] gap_total_reg; // gap to keep after frame
  logic [GAP_W-1:0] elapsed_reg; // idle cycles since last byte
  logic out_valid_reg;
  logic sum_mode; // accumulate instead of max

  ////////////////////////////////////////////////////////////////
  // cell buffer between rewriter and transmitter
  trl_cell_buffer #(
    .WIDTH(CELL_W),
    .DEPTH(BUF_DEPTH)
  ) u_cell_buffer (
    .clk(clk),
    .rst(rst),
    .flush(cell_buffer_flush), // RL22
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .wr_data({in_eof, in_preamble, in_data}),
    .rd_ready(pop),
    .rd_valid(buf_valid),
    .rd_data(buf_cell)
  );

  assign buf_pre = buf_cell[CELL_PRE];
  assign buf_eof = buf_cell[CELL_EOF];

  ////////////////////////////////////////////////////////////////
  // byte classification
  assign out_free = !out_valid_reg || out_ready;
  assign first = (st_reg == TRL_IDLE);
  // in the gap nothing moves, which is the whole point
  assign pop = (first || st_reg == TRL_DATA) && buf_valid && out_free;
  assign hdr_base = first ? '0 : hdr_cnt_reg;
  assign len_base = first ? '0 : len_reg;
  assign seen_base = first ? 1'b0 : seen_reg;
  // one header size serves every port that subtracts
  assign is_hdr = header_subtract_enable && !buf_pre
    && (hdr_base < header_byte_count); // RL5 RL6
  // these adjustments feed only payload length and spacing counter
  assign pay_byte = (!buf_pre || preamble_as_payload_sel) && !is_hdr; // RL4 RL7

  // per-frame payload and header counting
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hdr_cnt_reg <= '0;
      len_reg <= '0;
      seen_reg <= 1'b0;
    end
    else if (pop)
    begin
      if (!buf_pre && hdr_base != '1)
      begin
        hdr_cnt_reg <= hdr_base + 1'b1;
      end
      else
      begin
        hdr_cnt_reg <= hdr_base;
      end
      // saturate rather than wrap on jumbo frames
      if (pay_byte && len_base != '1)
      begin
        len_reg <= len_base + 1'b1;
      end
      else
      begin
        len_reg <= len_base;
      end
      seen_reg <= seen_base || pay_byte;
    end
  end

  // frame spacing down-counter
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fr_cnt_reg <= '0;
    end
    else if (pop && pay_byte)
    begin
      if (!seen_base)
      begin
        // load at first payload byte, which is itself counted
        fr_cnt_reg <= (frame_rate_start == '0) ? '0 : frame_rate_start - 1'b1; // RL15
      end
      else if (fr_cnt_reg != '0)
      begin
        fr_cnt_reg <= fr_cnt_reg - 1'b1; // RL16
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // output register towards the port module
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_valid_reg <= 1'b0;
      out_data <= '0;
      out_preamble <= 1'b0;
      out_eof <= 1'b0;
    end
    else if (out_free)
    begin
      out_valid_reg <= pop;
      if (pop)
      begin
        out_data <= buf_cell[BYTE_W-1:0];
        out_preamble <= buf_pre;
        out_eof <= buf_eof;
      end
    end
  end
  assign out_valid = out_valid_reg;

  ////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg <= TRL_IDLE;
    end
    else
    begin
      case (st_reg)
        TRL_IDLE, TRL_DATA:
        begin
          if (pop && buf_eof)
          begin
            st_reg <= TRL_CALC;
          end
          else if (pop)
          begin
            st_reg <= TRL_DATA;
          end
        end
        TRL_CALC:
        begin
          if (div_done)
          begin
            st_reg <= TRL_GAP;
          end
        end
        TRL_GAP:
        begin
          // lead accounts for the idle and output register stages
          if (GAP_W'(elapsed_reg + GAP_LEAD) >= gap_total_reg) // RL11
          begin
            st_reg <= TRL_IDLE;
          end
        end
        default:
        begin
          st_reg <= TRL_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // payload gap divider: (L*2^S*256 + carried) / R, one bit per cycle
  // trade-off: a serial divide keeps area small but sets a floor of
  // about 38 idle cycles after each frame while payload mode is on
  assign div_done = (st_reg == TRL_CALC) && (div_cnt_reg == '0);
  assign rem_shift = {rem_reg[RATIO_W-1:0], num_reg[NUM_W-1]};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_cnt_reg <= '0;
      num_reg <= '0;
      quo_reg <= '0;
      rem_reg <= '0;
    end
    else if (pop && buf_eof)
    begin
      div_cnt_reg <= payload_method_enable ? DIV_LOAD : '0;
    end
    else if (st_reg == TRL_CALC && div_cnt_reg == DIV_LOAD)
    begin
      // scale exponent above ten is not supported by software
      num_reg <= (NUM_W'(len_reg) << (PAYLOAD_SHIFT + gap_scale_exponent))
        + NUM_W'(frac_reg); // RL10 RL13 RL14
      quo_reg <= '0;
      rem_reg <= '0;
      div_cnt_reg <= div_cnt_reg - 1'b1;
    end
    else if (st_reg == TRL_CALC && div_cnt_reg != '0)
    begin
      num_reg <= {num_reg[NUM_W-2:0], 1'b0};
      // ratio is kept in range by software, so never zero
      if (rem_shift >= {1'b0, gap_stretch_ratio}) // RL12
      begin
        rem_reg <= rem_shift - {1'b0, gap_stretch_ratio};
        quo_reg <= {quo_reg[NUM_W-2:0], 1'b1};
      end
      else
      begin
        rem_reg <= rem_shift;
        quo_reg <= {quo_reg[NUM_W-2:0], 1'b0};
      end
      div_cnt_reg <= div_cnt_reg - 1'b1;
    end
  end

  // fraction left over is owed to the next frame
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      frac_reg <= '0;
    end
    else if (div_done && payload_method_enable)
    begin
      frac_reg <= rem_reg[RATIO_W-1:0]; // RL14
    end
  end

  ////////////////////////////////////////////////////////////////
  // per-method extra gaps, each enabled on its own
  always_comb
  begin
    ov_extra = '0;
    pl_extra = '0;
    fs_extra = '0;
    if (overhead_method_enable && gap_compensation_value > STD_GAP) // RL1 RL9
    begin
      ov_extra = GAP_W'(gap_compensation_value - STD_GAP) << gap_scale_exponent; // RL8
    end
    if (payload_method_enable) // RL1
    begin
      pl_extra = (|quo_reg[NUM_W-1:GAP_W]) ? '1 : quo_reg[GAP_W-1:0]; // RL8 RL10
    end
    if (frame_spacing_method_enable && fr_cnt_reg > FRAME_RATE_FLOOR) // RL1 RL17
    begin
      fs_extra = GAP_W'(fr_cnt_reg);
    end
  end

  // combine: sum only when spacing method is off
  assign sum_mode = gap_accumulate_enable && !frame_spacing_method_enable; // RL3
  assign sum_wide = {1'b0, ov_extra} + {1'b0, pl_extra};
  assign sum_extra = sum_wide[GAP_W] ? '1 : sum_wide[GAP_W-1:0];

  always_comb
  begin
    max_extra = ov_extra;
    if (pl_extra > max_extra)
    begin
      max_extra = pl_extra; // RL2
    end
    if (fs_extra > max_extra)
    begin
      max_extra = fs_extra; // RL2
    end
  end

  assign extra_sel = sum_mode ? sum_extra : max_extra; // RL2 RL3
  assign total_wide = {1'b0, extra_sel} + (GAP_W + 1)'(STD_GAP);

  // total gap latched when the extra gap is known
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gap_total_reg <= GAP_W'(STD_GAP);
    end
    else if (div_done)
    begin
      gap_total_reg <= total_wide[GAP_W] ? '1 : total_wide[GAP_W-1:0]; // RL11
    end
  end

  // idle byte times counted once the last byte has left
  always_ff @(posedge clk)
  begin
    if (rst || st_reg == TRL_DATA || st_reg == TRL_IDLE)
    begin
      elapsed_reg <= '0;
    end
    else if (!out_valid_reg && elapsed_reg != '1)
    begin
      elapsed_reg <= elapsed_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // error events; a refused byte that is withdrawn was lost
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stall_reg <= 1'b0;
    end
    else
    begin
      stall_reg <= in_valid && !in_ready;
    end
  end
  assign ovf_event = stall_reg && !in_valid;
  assign unf_event = (st_reg == TRL_DATA) && !buf_valid && out_free;

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cell_buffer_overflow_flag <= 1'b0;
      cell_buffer_underrun_flag <= 1'b0;
      rate_limit_flag <= 1'b0;
    end
    else
    begin
      cell_buffer_overflow_flag <= ovf_event
        || (cell_buffer_overflow_flag && !cell_buffer_overflow_clear); // RL18 RL21
      cell_buffer_underrun_flag <= unf_event
        || (cell_buffer_underrun_flag && !cell_buffer_underrun_clear); // RL19 RL21
      rate_limit_flag <= (div_done && extra_sel != '0)
        || (rate_limit_flag && !rate_limit_clear); // RL20 RL21
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  a_max_of_methods: assert property (@(posedge clk) disable iff (rst) // RL2
    div_done && !sum_mode |-> extra_sel >= ov_extra
      && extra_sel >= pl_extra && extra_sel >= fs_extra)
    else $error("extra gap below an enabled method");
  a_accum_sum: assert property (@(posedge clk) disable iff (rst) // RL3
    div_done && sum_mode && !sum_wide[GAP_W]
      |-> extra_sel == ov_extra + pl_extra)
    else $error("accumulate mode did not add gaps");
  a_overhead_min: assert property (@(posedge clk) disable iff (rst) // RL9
    div_done && overhead_method_enable && gap_compensation_value > STD_GAP
      |=> gap_total_reg >= GAP_W'($past(gap_compensation_value)))
    else $error("overhead gap below compensation value");
  a_plain_gap: assert property (@(posedge clk) disable iff (rst) // RL11
    div_done && !overhead_method_enable && !payload_method_enable
      && !frame_spacing_method_enable |=> gap_total_reg == GAP_W'(STD_GAP))
    else $error("standard gap not twelve");
  a_gap_waits: assert property (@(posedge clk) disable iff (rst) // RL11
    st_reg == TRL_GAP && GAP_W'(elapsed_reg + GAP_LEAD) < gap_total_reg
      |=> st_reg == TRL_GAP && (!out_valid || out_eof))
    else $error("gap left early");
  a_spacing_load: assert property (@(posedge clk) disable iff (rst) // RL15
    pop && pay_byte && !seen_base && frame_rate_start != '0
      |=> fr_cnt_reg == $past(frame_rate_start) - 1'b1)
    else $error("spacing counter not loaded");
  a_spacing_dec: assert property (@(posedge clk) disable iff (rst) // RL16
    pop && pay_byte && seen_base && fr_cnt_reg != '0
      |=> fr_cnt_reg == $past(fr_cnt_reg) - 1'b1)
    else $error("spacing counter not decremented");
  a_spacing_floor: assert property (@(posedge clk) disable iff (rst) // RL17
    div_done && fr_cnt_reg <= FRAME_RATE_FLOOR |-> fs_extra == '0)
    else $error("spacing stretched at or below twelve");
  a_ovf_sticky: assert property (@(posedge clk) disable iff (rst) // RL18
    ovf_event |=> cell_buffer_overflow_flag ##1
      (cell_buffer_overflow_flag || $past(cell_buffer_overflow_clear)))
    else $error("overflow flag not held");
  a_unf_sticky: assert property (@(posedge clk) disable iff (rst) // RL19
    unf_event |=> cell_buffer_underrun_flag)
    else $error("underrun flag not set");
  a_limit_sticky: assert property (@(posedge clk) disable iff (rst) // RL20
    div_done && extra_sel != '0 |=> rate_limit_flag)
    else $error("rate limit flag not set");
  a_clear_w1c: assert property (@(posedge clk) disable iff (rst) // RL21
    rate_limit_flag && rate_limit_clear && !(div_done && extra_sel != '0)
      |=> !rate_limit_flag)
    else $error("rate limit flag not cleared");
endmodule

// file: trl_port_model.sv
// port module stand-in: takes bytes, measures idle gap between frames
module trl_port_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // byte stream from the stretcher
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [7:0] out_data,
  input wire logic out_eof,
  // pacing set by the bench
  input wire logic hold,
  input wire logic slow
);
  logic [7:0] rx_q[$]; // bytes taken, in order
  int gap_cnt = 0; // idle cycles since last eof
  int last_gap = 0; // gap seen before the latest frame
  int frames = 0; // frames completed
  logic in_gap = 1'b0; // between eof and next byte
  logic tog = 1'b0; // half-rate pacing
  // slow takes every other cycle, hold stalls outright
  assign out_ready = !hold && (!slow || tog);
  ////////////////////////////////////////////////////////////
  // only cycles with out_valid low count, so stalls never inflate the gap
  always @(posedge clk)
  begin
    tog <= rst ? 1'b0 : !tog;
    if (out_valid && out_ready)
    begin
      rx_q.push_back(out_data);
      if (in_gap)
        last_gap = gap_cnt;
      in_gap = out_eof;
      gap_cnt = 0;
      frames += out_eof;
    end
    else if (!out_valid && in_gap)
      gap_cnt++;
  end
endmodule

// file: trl_ipg_stretcher_tb_top.sv
module trl_ipg_stretcher_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, g) \
    begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s exp %0d got %0d", nm, e, g); end end
  // clock, reset and input stream
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic in_valid = 1'b0, in_preamble = 1'b0, in_eof = 1'b0, in_ready;
  logic [7:0] in_data = 8'h00, out_data, gap_compensation_value = 8'h00;
  logic [7:0] header_byte_count = 8'h03; // one shared value
  logic out_valid, out_ready, out_preamble, out_eof;
  // method selection
  logic overhead_method_enable = 1'b0, payload_method_enable = 1'b0;
  logic frame_spacing_method_enable = 1'b0, gap_accumulate_enable = 1'b0;
  logic preamble_as_payload_sel = 1'b0, header_subtract_enable = 1'b0;
  logic [3:0] gap_scale_exponent = 4'h0;
  logic [18:0] gap_stretch_ratio = 19'h00500;
  logic [15:0] frame_rate_start = 16'h0000;
  // flags and maintenance
  logic cell_buffer_flush = 1'b0, cell_buffer_overflow_flag;
  logic cell_buffer_underrun_flag, rate_limit_flag;
  logic cell_buffer_overflow_clear = 1'b0, cell_buffer_underrun_clear = 1'b0;
  logic rate_limit_clear = 1'b0;
  logic hold = 1'b0, slow = 1'b0; // partner pacing
  int n_fail = 0;
  int n_checks = 0;
  always #4 clk = !clk;
  ////////////////////////////////////////////////////////////
  trl_ipg_stretcher u_trl_ipg_stretcher (.clk, .rst, .in_valid, .in_ready, .in_data,
    .in_preamble, .in_eof, .out_valid, .out_ready, .out_data, .out_preamble, .out_eof,
    .overhead_method_enable, .payload_method_enable, .frame_spacing_method_enable,
    .gap_accumulate_enable, .preamble_as_payload_sel, .header_subtract_enable,
    .gap_scale_exponent, .gap_compensation_value, .gap_stretch_ratio, .frame_rate_start,
    .header_byte_count, .cell_buffer_flush, .cell_buffer_overflow_flag,
    .cell_buffer_overflow_clear, .cell_buffer_underrun_flag, .cell_buffer_underrun_clear,
    .rate_limit_flag, .rate_limit_clear);
  trl_port_model u_trl_port_model (.clk, .rst, .out_valid, .out_ready, .out_data, .out_eof,
    .hold, .slow);
  ////////////////////////////////////////////////////////////
  // verdict, reached from the main sequence or the watchdog
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // reset held 20 cycles; also clears the carried remainder
  task do_reset;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
  endtask
  // method bits: overhead, payload, spacing, accumulate, preamble, header
  task cfg(input logic [5:0] m, input logic [3:0] s, input logic [7:0] c,
    input logic [18:0] r, input logic [15:0] st);
    {overhead_method_enable, payload_method_enable, frame_spacing_method_enable,
      gap_accumulate_enable, preamble_as_payload_sel, header_subtract_enable} = m;
    gap_scale_exponent = s;
    gap_compensation_value = c;
    gap_stretch_ratio = r;
    frame_rate_start = st;
  endtask
  // offer one byte; in_ready is registered state, so its value before the edge holds at it
  task put(input logic [7:0] d, input logic p, input logic e);
    logic ok;
    in_valid = 1'b1;
    in_data = d;
    in_preamble = p;
    in_eof = e;
    for (int k = 0; k < 3000; k++)
    begin
      @(negedge clk);
      ok = in_ready;
      @(posedge clk);
      #1;
      if (ok === 1'b1)
        break;
    end
  endtask
  // one frame: np preamble bytes then nd data bytes
  task frame(input int np, input int nd);
    for (int i = 0; i < np + nd; i++)
      put(8'(i + 16), i < np, i == np + nd - 1);
    in_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // nf frames, then wait until the last is out and its gap calc has settled
  task run(input int nf, input int np, input int nd);
    int f0;
    f0 = u_trl_port_model.frames;
    repeat (nf) frame(np, nd);
    for (int k = 0; k < 3000 && u_trl_port_model.frames < f0 + nf; k++)
      @(posedge clk);
    repeat (60) @(posedge clk);
    #1;
  endtask
  // gap may exceed the total only by a few pipeline cycles
  task gap(input int t);
    int g;
    g = u_trl_port_model.last_gap;
    `CHK("gap", t, (g >= t && g <= t + 4) ? t : g)
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk);
    #1 s = 1'b0;
    @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////
  // plain gap, then overhead at several scales
  task t_overhead;
    int sc[3] = '{1, 5, 10};
    `CHK("in_ready", 1'b1, in_ready)
    `CHK("rate_flag", 1'b0, rate_limit_flag)
    run(2, 2, 10);
    gap(12);
    `CHK("rate_flag", 1'b0, rate_limit_flag)
    foreach (sc[i])
    begin
      cfg(6'b100000, 4'(sc[i]), 8'h0D, 19'h00500, 16'h0000);
      run(2, 0, 4);
      gap(12 + (1 << sc[i]));
    end
    cfg(6'b100011, 4'h1, 8'h14, 19'h00500, 16'h0000);
    run(2, 2, 10);
    gap(28);
    `CHK("rate_flag", 1'b1, rate_limit_flag)
    pulse(rate_limit_clear);
    `CHK("rate_flag", 1'b0, rate_limit_flag)
    $display("done overhead");
  endtask
  // spacing counter against preamble, header and the boundary at 12
  task t_spacing;
    int tb[6][4] = '{'{0, 0, 40, 42}, '{1, 0, 40, 40}, '{0, 1, 40, 45},
      '{0, 0, 22, 12}, '{0, 0, 23, 25}, '{1, 1, 40, 43}};
    foreach (tb[i])
    begin
      cfg({4'b0010, 1'(tb[i][0]), 1'(tb[i][1])}, 4'h0, 8'h00, 19'h00500, 16'(tb[i][2]));
      run(2, 2, 10);
      gap(tb[i][3]);
      `CHK("rate_flag", tb[i][3] > 12, rate_limit_flag)
      pulse(rate_limit_clear);
    end
    cfg(6'b101100, 4'h1, 8'h14, 19'h00500, 16'd40);
    run(2, 2, 10);
    gap(42);
    $display("done spacing");
  endtask
  // payload gap alone, max with overhead, summed with overhead, remainder carry
  task t_payload;
    cfg(6'b010000, 4'h6, 8'h14, 19'h00500, 16'h0000);
    run(2, 2, 10);
    gap(140);
    cfg(6'b110000, 4'h6, 8'h14, 19'h00500, 16'h0000);
    run(2, 2, 10);
    gap(524);
    cfg(6'b110100, 4'h6, 8'h14, 19'h00500, 16'h0000);
    run(2, 2, 10);
    gap(652);
    do_reset;
    cfg(6'b010000, 4'h6, 8'h00, 19'h00480, 16'h0000);
    run(6, 2, 10);
    gap(155);
    $display("done payload");
  endtask
  // fill buffer against a stalled port, then drain at half rate
  task t_buffer;
    int f0;
    do_reset; // cuts the gap left by the previous test
    u_trl_port_model.rx_q.delete();
    f0 = u_trl_port_model.frames;
    hold = 1'b1;
    fork
      frame(1, 5);
    join_none
    repeat (20) @(posedge clk);
    #1;
    `CHK("in_ready", 1'b0, in_ready)
    `CHK("out_valid", 1'b1, out_valid)
    `CHK("out_pre", 1'b1, out_preamble)
    hold = 1'b0;
    slow = 1'b1;
    for (int k = 0; k < 200 && u_trl_port_model.frames == f0; k++)
      @(posedge clk);
    repeat (20) @(posedge clk);
    #1 slow = 1'b0;
    `CHK("rx_count", 6, u_trl_port_model.rx_q.size())
    foreach (u_trl_port_model.rx_q[i])
      `CHK("rx_byte", 8'(i + 16), u_trl_port_model.rx_q[i])
    $display("done buffer");
  endtask
  // overflow via a withdrawn refused byte, underrun via a stalled frame
  task t_flags;
    cell_buffer_flush = 1'b1;
    in_valid = 1'b1;
    repeat (2) @(posedge clk);
    #1 in_valid = 1'b0;
    cell_buffer_flush = 1'b0;
    // let the previous gap run out so the lone byte below leaves at once
    repeat (120) @(posedge clk);
    #1;
    `CHK("overflow", 1'b1, cell_buffer_overflow_flag)
    pulse(cell_buffer_overflow_clear);
    `CHK("overflow", 1'b0, cell_buffer_overflow_flag)
    `CHK("underrun", 1'b0, cell_buffer_underrun_flag)
    put(8'h01, 1'b0, 1'b0);
    in_valid = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    frame(0, 1);
    repeat (60) @(posedge clk);
    #1;
    `CHK("underrun", 1'b1, cell_buffer_underrun_flag)
    pulse(cell_buffer_underrun_clear);
    `CHK("underrun", 1'b0, cell_buffer_underrun_flag)
    $display("done flags");
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    do_reset;
    t_overhead;
    t_spacing;
    t_payload;
    t_buffer;
    t_flags;
    end_of_test;
  end
  // watchdog: all tests need well under 40000 cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    end_of_test;
  end
endmodule
